//--- hw/wsc_bcd.sv
// bcd helpers: validity check and binary conversion of a four digit word
`timescale 1ns/1ps
`default_nettype none
module wsc_bcd (
    // value under test
    input  wire logic [15:0] bcd_in,
    // results
    output logic             is_bcd,
    output logic [13:0]      bin_out
);
    // each nibble must be a decimal digit
    always_comb begin
        is_bcd  = (bcd_in[3:0] < 4'hA) && (bcd_in[7:4] < 4'hA) &&
                  (bcd_in[11:8] < 4'hA) && (bcd_in[15:12] < 4'hA);
        bin_out = 14'(bcd_in[15:12]) * 14'd1000 + 14'(bcd_in[11:8]) * 14'd100 +
                  14'(bcd_in[7:4]) * 14'd10 + 14'(bcd_in[3:0]);
    end
endmodule
`default_nettype wire

//--- hw/wsc_bin2bcd.sv
// binary to four digit bcd conversion by shift and add
`timescale 1ns/1ps
`default_nettype none
module wsc_bin2bcd (
    // binary value, below 10000
    input  wire logic [13:0] bin_in,
    // bcd result
    output logic [15:0]      bcd_out
);
    logic [29:0] work;
    // double dabble, combinational
    always_comb begin
        work = {16'h0000, bin_in};
        for (int i = 0; i < 14; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (work[14+4*d +: 4] > 4'h4) begin
                    work[14+4*d +: 4] = work[14+4*d +: 4] + 4'h3;
                end
            end
            work = {work[28:0], 1'b0};
        end
        bcd_out = work[29:14];
    end
endmodule
`default_nettype wire

//--- hw/wsc_unit.sv
// word lookup, expansion block read and indirect bank select execution unit
// Behaviour
// - lookup compares range words upward until the first match when enabled
// - fault when lookup count not bcd 0001..6655
// - match sets flag, writes lowest match position
// - data area match writes absolute address
// - other area match writes offset from start
// - no match clears flag, result untouched
// - fault on bad indirect data word operand
// - read count must be bcd 0001..3000
// - read source must be bcd 7000..9999
// - read copies count words in order
// - fault when source word not allocated
// - read in progress finishes on power loss
// - bank select decodes five control codes
// - fault on any other control code
// - interrupt entry forces data area target
// - scan start forces data area target
// - status word: bank low, target high
// - tool reads show data area target
// - extra accesses reach current bank only
`timescale 1ns/1ps
`default_nettype none
module wsc_unit #(
    parameter int AW = 16
) (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // instruction issue from the sequencer
    input  wire logic          op_start,
    input  wire logic [1:0]    op_code,
    input  wire logic          exec_cond,
    input  wire logic [15:0]   count_operand,
    input  wire logic [AW-1:0] range_addr,
    input  wire logic          range_in_data_area,
    input  wire logic [15:0]   source_operand,
    input  wire logic [AW-1:0] dest_addr,
    input  wire logic [AW-1:0] compare_addr,
    input  wire logic [15:0]   control_operand,
    input  wire logic          indirect_bad,
    input  wire logic [15:0]   expansion_limit,
    // system events
    input  wire logic          scan_start,
    input  wire logic          interrupt_entry,
    input  wire logic          power_fail,
    // word memory port
    output logic               mem_req,
    output logic               mem_we,
    output logic               mem_expansion,
    output logic [AW-1:0]      mem_addr,
    output logic [15:0]        mem_wdata,
    input  wire logic          mem_ack,
    input  wire logic [15:0]   mem_rdata,
    // extra bank store selection
    output logic [1:0]         extra_bank,
    output logic               indirect_to_extra,
    // status word reads
    input  wire logic          status_rd,
    input  wire logic          status_rd_tool,
    input  wire logic [15:0]   status_rd_addr,
    output logic [15:0]        status_rdata,
    // completion
    output logic               op_done,
    output logic               op_busy,
    output logic               match_flag,
    output logic               fault_flag
);
    // the position arithmetic needs fourteen address bits
    if (AW < 14) $error("address width too small");

    typedef enum logic [2:0] {
        WSC_IDLE, WSC_FETCH_CMP, WSC_SCAN, WSC_WRITE_RES, WSC_RD_SRC, WSC_WR_DST, WSC_DONE
    } wsc_state_t;

    wsc_state_t      state_reg;
    logic [13:0]     count_reg;
    logic [13:0]     index_reg;
    logic [15:0]     cmp_reg;
    logic [15:0]     data_reg;
    logic            in_data_reg;
    logic [AW-1:0]   src_reg;
    logic [AW-1:0]   dst_reg;
    logic [AW-1:0]   cadr_reg;
    logic [1:0]      bank_reg;
    logic            target_reg;
    logic            match_reg;
    logic            fault_reg;
    logic            done_reg;

    logic            cnt_bcd;
    logic [13:0]     cnt_bin;
    logic            src_bcd;
    logic [13:0]     src_bin;
    logic [13:0]     pos_bin;
    logic [15:0]     pos_bcd;
    logic            lookup_fault;
    logic            read_fault;
    logic            bank_fault;
    logic [15:0]     last_src;
    logic [13:0]     pos_sum;

    // decode helpers for the operands
    wsc_bcd u_cnt_bcd (
        .bcd_in  (count_operand),
        .is_bcd  (cnt_bcd),
        .bin_out (cnt_bin)
    );
    wsc_bcd u_src_bcd (
        .bcd_in  (source_operand),
        .is_bcd  (src_bcd),
        .bin_out (src_bin)
    );
    wsc_bin2bcd u_pos (
        .bin_in  (pos_bin),
        .bcd_out (pos_bcd)
    );

    // bcd comparison holds since bcd orders like binary nibble by nibble
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // last source word in binary, checked against the configured expansion span
    assign last_src = {2'b00, src_bin} + {2'b00, cnt_bin} - 16'h0001;
    // latched range start, so a later operand change cannot skew the result
    assign pos_sum  = 14'(src_reg) + index_reg;

    // data area match reports absolute address, others the offset
    assign pos_bin = in_data_reg ? pos_sum : index_reg;

    // operand checks at issue time
    always_comb begin
        lookup_fault = indirect_bad || !cnt_bcd ||
                       !in_range(count_operand, wsc_pkg::LOOKUP_CNT_MIN, wsc_pkg::LOOKUP_CNT_MAX);
        read_fault   = indirect_bad || !cnt_bcd || !src_bcd ||
                       !in_range(count_operand, wsc_pkg::READ_CNT_MIN, wsc_pkg::READ_CNT_MAX) ||
                       !in_range(source_operand, wsc_pkg::READ_SRC_MIN, wsc_pkg::READ_SRC_MAX) ||
                       (last_src > {2'b00, expansion_limit[13:0]});
        bank_fault   = indirect_bad ||
                       !((control_operand == wsc_pkg::SEL_DATA_AREA) ||
                         (control_operand == wsc_pkg::SEL_CURRENT) ||
                         ((control_operand >= wsc_pkg::SEL_BANK0) &&
                          (control_operand <= wsc_pkg::SEL_BANK2)));
    end

    // sequencer for the two memory instructions
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= WSC_IDLE;
            count_reg     <= '0;
            index_reg     <= '0;
            cmp_reg       <= 16'h0000;
            data_reg      <= 16'h0000;
            in_data_reg   <= 1'b0;
            src_reg       <= '0;
            dst_reg       <= '0;
            cadr_reg      <= '0;
            match_reg     <= 1'b0;
            fault_reg     <= 1'b0;
        end else begin
            case (state_reg)
                WSC_IDLE: begin
                    // a false execution condition leaves everything alone
                    if (op_start && exec_cond) begin
                        fault_reg <= 1'b0;
                        index_reg <= '0;
                        count_reg <= cnt_bin;
                        in_data_reg <= range_in_data_area;
                        if (op_code == 2'(wsc_pkg::WSC_OP_LOOKUP)) begin
                            src_reg       <= range_addr;
                            cadr_reg      <= compare_addr;
                            if (lookup_fault) begin
                                fault_reg <= 1'b1;
                                state_reg <= WSC_DONE;
                            end else begin
                                state_reg <= WSC_FETCH_CMP;
                            end
                        end else if (op_code == 2'(wsc_pkg::WSC_OP_READ)) begin
                            src_reg       <= AW'(src_bin);
                            dst_reg       <= dest_addr;
                            if (read_fault) begin
                                fault_reg <= 1'b1;
                                state_reg <= WSC_DONE;
                            end else begin
                                state_reg <= WSC_RD_SRC;
                            end
                        end else begin
                            fault_reg <= bank_fault;
                            state_reg <= WSC_DONE;
                        end
                    end
                end
                WSC_FETCH_CMP: begin
                    if (mem_ack) begin
                        cmp_reg   <= mem_rdata;
                        state_reg <= WSC_SCAN;
                    end
                end
                WSC_SCAN: begin
                    // upward scan; the first hit is the lowest address
                    if (mem_ack) begin
                        if (mem_rdata == cmp_reg) begin
                            match_reg <= 1'b1;
                            state_reg <= WSC_WRITE_RES;
                        end else if (index_reg == count_reg - 14'd1) begin
                            match_reg <= 1'b0;
                            state_reg <= WSC_DONE;
                        end else begin
                            index_reg <= index_reg + 14'd1;
                        end
                    end
                end
                WSC_WRITE_RES: begin
                    if (mem_ack) begin
                        state_reg <= WSC_DONE;
                    end
                end
                WSC_RD_SRC: begin
                    // power_fail is ignored here so the copy runs to its end
                    if (mem_ack) begin
                        data_reg  <= mem_rdata;
                        state_reg <= WSC_WR_DST;
                    end
                end
                WSC_WR_DST: begin
                    if (mem_ack) begin
                        if (index_reg == count_reg - 14'd1) begin
                            state_reg <= WSC_DONE;
                        end else begin
                            index_reg <= index_reg + 14'd1;
                            state_reg <= WSC_RD_SRC;
                        end
                    end
                end
                WSC_DONE: begin
                    state_reg <= WSC_IDLE;
                end
                default: begin
                    state_reg <= WSC_IDLE;
                end
            endcase
        end
    end

    // completion pulse one cycle after the last step
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == WSC_DONE);
        end
    end

    // indirect target and current bank; scan and interrupt win over a select
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_reg <= 1'b0;
            bank_reg   <= 2'(wsc_pkg::BANK_RESET);
        end else if (scan_start || interrupt_entry) begin
            target_reg <= 1'b0;
        end else if (state_reg == WSC_IDLE && op_start && exec_cond &&
                     op_code == 2'(wsc_pkg::WSC_OP_BANK) && !bank_fault) begin
            if (control_operand == wsc_pkg::SEL_DATA_AREA) begin
                target_reg <= 1'b0;
            end else if (control_operand == wsc_pkg::SEL_CURRENT) begin
                target_reg <= 1'b1;
            end else begin
                target_reg <= 1'b1;
                bank_reg   <= control_operand[1:0];
            end
        end
    end

    // status word read; tool reads always show the data area target
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_rdata <= 16'h0000;
        end else if (status_rd && status_rd_addr == wsc_pkg::STATUS_OFFSET) begin
            status_rdata <= {(target_reg && !status_rd_tool) ? wsc_pkg::TARGET_EXTRA
                                                              : wsc_pkg::TARGET_DATA_AREA,
                             6'h00, bank_reg};
        end else begin
            status_rdata <= 16'h0000;
        end
    end

    // memory port drive per state
    always_comb begin
        mem_req       = 1'b0;
        mem_we        = 1'b0;
        mem_expansion = 1'b0;
        mem_addr      = '0;
        mem_wdata     = 16'h0000;
        case (state_reg)
            WSC_FETCH_CMP: begin
                mem_req  = 1'b1;
                mem_addr = cadr_reg;
            end
            WSC_SCAN: begin
                mem_req  = 1'b1;
                mem_addr = src_reg + AW'(index_reg);
            end
            WSC_WRITE_RES: begin
                mem_req   = 1'b1;
                mem_we    = 1'b1;
                mem_addr  = cadr_reg + AW'(1);
                mem_wdata = pos_bcd;
            end
            WSC_RD_SRC: begin
                mem_req       = 1'b1;
                mem_expansion = 1'b1;
                mem_addr      = src_reg + AW'(index_reg);
            end
            WSC_WR_DST: begin
                mem_req   = 1'b1;
                mem_we    = 1'b1;
                mem_addr  = dst_reg + AW'(index_reg);
                mem_wdata = data_reg;
            end
            default: begin
                mem_req = 1'b0;
            end
        endcase
    end

    // outputs
    assign extra_bank        = bank_reg;
    assign indirect_to_extra = target_reg;
    assign op_done           = done_reg;
    assign op_busy           = (state_reg != WSC_IDLE);
    assign match_flag        = match_reg;
    assign fault_flag        = fault_reg;
endmodule
`default_nettype wire

//--- include/wsc_pkg.sv
// shared constants and types for the word lookup, block read and bank select unit
package wsc_pkg;
    // status word location and layout
    localparam logic [15:0] STATUS_OFFSET     = 16'h178F;
    localparam int          BANK_LSB          = 0;
    localparam int          TARGET_LSB        = 8;
    localparam logic [7:0]  TARGET_DATA_AREA  = 8'h00;
    localparam logic [7:0]  TARGET_EXTRA      = 8'h80;
    localparam logic [7:0]  BANK_RESET        = 8'h00;
    localparam logic [7:0]  BANK_MAX          = 8'h02;
    // bank select control codes
    localparam logic [15:0] SEL_DATA_AREA     = 16'h0000;
    localparam logic [15:0] SEL_CURRENT       = 16'hE000;
    localparam logic [15:0] SEL_BANK0         = 16'hE0B0;
    localparam logic [15:0] SEL_BANK2         = 16'hE0B2;
    // operand limits, bcd
    localparam logic [15:0] LOOKUP_CNT_MIN    = 16'h0001;
    localparam logic [15:0] LOOKUP_CNT_MAX    = 16'h6655;
    localparam logic [15:0] READ_CNT_MIN      = 16'h0001;
    localparam logic [15:0] READ_CNT_MAX      = 16'h3000;
    localparam logic [15:0] READ_SRC_MIN      = 16'h7000;
    localparam logic [15:0] READ_SRC_MAX      = 16'h9999;
    // data word area size, bcd last address
    localparam logic [15:0] DATA_AREA_LAST    = 16'h9999;
    // operations
    typedef enum logic [1:0] {
        WSC_OP_LOOKUP,
        WSC_OP_READ,
        WSC_OP_BANK
    } wsc_op_t;
endpackage

//--- testbench/wsc_mem_model.sv
// word memory on the far side of the unit's memory port
`timescale 1ns/1ps
`default_nettype none
module wsc_mem_model (
    // clock and stall control
    input wire logic        sys_clk,
    input wire logic        slow,
    // memory port
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        mem_expansion,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic            mem_ack,
    output logic [15:0]     mem_rdata
);
    logic [15:0] dmem [0:1023];
    logic [15:0] xmem [0:1023];
    logic        tog = 1'b0;
    // slow mode answers every other cycle so the unit must hold its request
    always @(posedge sys_clk) tog <= !tog;
    assign mem_ack = mem_req && (!slow || tog);
    // no answer: a pattern flipping each cycle, never the last data
    assign mem_rdata = (mem_ack && !mem_we) ? (mem_expansion ? xmem[mem_addr[9:0]] : dmem[mem_addr[9:0]])
                                            : {8{tog, !tog}};
    always @(posedge sys_clk) begin
        if (mem_req && mem_we && mem_ack && !mem_expansion) dmem[mem_addr[9:0]] <= mem_wdata;
    end
endmodule
`default_nettype wire

//--- testbench/wsc_unit_chk.sv
// assertion checker for the lookup, block read and bank select unit
`timescale 1ns/1ps
`default_nettype none
module wsc_unit_chk #(
    parameter int AW = 16
) (
    // clock and reset
    input wire logic          sys_clk,
    input wire logic          rst_n,
    // issue
    input wire logic          op_start,
    input wire logic [1:0]    op_code,
    input wire logic          exec_cond,
    input wire logic [15:0]   control_operand,
    input wire logic          indirect_bad,
    input wire logic          scan_start,
    input wire logic          interrupt_entry,
    // memory port
    input wire logic          mem_req,
    input wire logic          mem_ack,
    input wire logic [AW-1:0] mem_addr,
    // bank state and status reads
    input wire logic [1:0]    extra_bank,
    input wire logic          indirect_to_extra,
    input wire logic          status_rd,
    input wire logic          status_rd_tool,
    input wire logic [15:0]   status_rd_addr,
    input wire logic [15:0]   status_rdata,
    // completion
    input wire logic          op_done,
    input wire logic          op_busy,
    input wire logic          match_flag,
    input wire logic          fault_flag
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // taken issue and a status read aimed at the status word
    logic take;
    logic sel;
    logic hit;
    assign take = op_start && exec_cond && !op_busy;
    assign sel = take && op_code == 2'h2 && !indirect_bad;
    assign hit = status_rd && status_rd_addr == wsc_pkg::STATUS_OFFSET;
    ignore_off_a: assert property (op_start && !exec_cond && !op_busy |=> !op_busy)
        else $error("disabled issue started work");
    bad_ind_a: assert property (take && indirect_bad |-> ##2 op_done && fault_flag)
        else $error("bad indirect operand not faulted");
    bad_code_a: assert property (sel && control_operand == 16'hE0B3 |-> ##2 op_done && fault_flag)
        else $error("illegal select code not faulted");
    bank_one_a: assert property (sel && control_operand == 16'hE0B1 |-> ##2 extra_bank == 2'h1 && indirect_to_extra)
        else $error("bank one select not applied");
    event_home_a: assert property (scan_start || interrupt_entry |=> !indirect_to_extra)
        else $error("target not returned to data area");
    status_prog_a: assert property (hit && !status_rd_tool |=>
        status_rdata == {$past(indirect_to_extra) ? 8'h80 : 8'h00, 6'h00, $past(extra_bank)})
        else $error("status word wrong");
    status_tool_a: assert property (hit && status_rd_tool |=> status_rdata == {14'h0000, $past(extra_bank)})
        else $error("tool status high byte not data area");
    match_hold_a: assert property (!$stable(match_flag) |-> $past(op_busy))
        else $error("match flag moved while idle");
    mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped before ack");
endmodule
`default_nettype wire

//--- testbench/wsc_unit_tb_top.sv
// self-checking bench for the lookup, block read and bank select unit
`timescale 1ns/1ps
`default_nettype none
module wsc_unit_tb_top;
    logic        sys_clk = 1'b0, rst_n = 1'b0, op_start = 1'b0, exec_cond = 1'b1, slow = 1'b0;
    logic        range_in_data_area = 1'b1, indirect_bad = 1'b0, scan_start = 1'b0, interrupt_entry = 1'b0;
    logic        power_fail = 1'b0, status_rd = 1'b0, status_rd_tool = 1'b0, mem_ack, mem_req, mem_we;
    logic        mem_expansion, op_done, op_busy, match_flag, fault_flag, indirect_to_extra;
    logic [1:0]  op_code = 2'h0, extra_bank;
    logic [15:0] count_operand = 16'h0001, range_addr = 16'h0000, source_operand = 16'h7000, dest_addr = 16'h0000;
    logic [15:0] compare_addr = 16'h0000, control_operand = 16'h0000, expansion_limit = 16'h270F;
    logic [15:0] status_rd_addr = wsc_pkg::STATUS_OFFSET, mem_addr, mem_wdata, mem_rdata, status_rdata;
    logic [49:0] bad [9] = '{{2'h0, 16'h0000, 32'h0}, {2'h0, 16'h6656, 32'h0}, {2'h0, 16'h12A4, 32'h0},
        {2'h1, 16'h0000, 16'h7000, 16'h0}, {2'h1, 16'h3001, 16'h7000, 16'h0}, {2'h1, 16'h0003, 16'h6999, 16'h0},
        {2'h1, 16'h0003, 16'h9998, 16'h0}, {2'h2, 32'h0, 16'hE0B3}, {2'h2, 32'h0, 16'h0001}};
    logic [15:0] codes [5] = '{16'hE0B2, 16'hE000, 16'h0000, 16'hE0B0, 16'hE0B1};
    int          err_total = 0, check_count = 0, cyc = 0, seed = 90, got_done = 0, bank = 0, tgt = 0;
    always #5 sys_clk = ~sys_clk;
    wsc_unit #(.AW(16)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .op_start(op_start), .op_code(op_code), .exec_cond(exec_cond),
        .count_operand(count_operand), .range_addr(range_addr), .range_in_data_area(range_in_data_area),
        .source_operand(source_operand), .dest_addr(dest_addr), .compare_addr(compare_addr),
        .control_operand(control_operand), .indirect_bad(indirect_bad), .expansion_limit(expansion_limit),
        .scan_start(scan_start), .interrupt_entry(interrupt_entry), .power_fail(power_fail),
        .mem_req(mem_req), .mem_we(mem_we), .mem_expansion(mem_expansion), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .extra_bank(extra_bank),
        .indirect_to_extra(indirect_to_extra), .status_rd(status_rd), .status_rd_tool(status_rd_tool),
        .status_rd_addr(status_rd_addr), .status_rdata(status_rdata), .op_done(op_done), .op_busy(op_busy),
        .match_flag(match_flag), .fault_flag(fault_flag));
    wsc_mem_model u_mem (.sys_clk(sys_clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
        .mem_expansion(mem_expansion), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    function automatic logic [15:0] bcd(input int v);
        return 16'(((v / 1000) % 10) * 4096 + ((v / 100) % 10) * 256 + ((v / 10) % 10) * 16 + v % 10);
    endfunction
    // caller sets operands at a falling edge first; waits bounded for done
    task automatic go(input logic [1:0] c);
        op_code = c;
        op_start = 1'b1;
        @(negedge sys_clk);
        op_start = 1'b0;
        got_done = 0;
        for (int i = 0; i < 400 && got_done == 0; i++) begin
            @(posedge sys_clk);
            #1;
            got_done = int'(op_done === 1'b1);
        end
        @(negedge sys_clk);
    endtask
    task automatic rd_st(input logic [15:0] a, input logic tool, input logic [15:0] exp);
        @(negedge sys_clk);
        status_rd = 1'b1;
        status_rd_tool = tool;
        status_rd_addr = a;
        @(negedge sys_clk);
        status_rd = 1'b0;
        chk(status_rdata, exp, "status");
    endtask
    // bench model: lowest match wins, position absolute in data area else offset
    task automatic lookup(input int ra, input int n, input int ca, input logic dm);
        int          hit;
        logic [15:0] old;
        hit = -1;
        old = u_mem.dmem[ca + 1];
        for (int i = n - 1; i >= 0; i--) if (u_mem.dmem[ra + i] === u_mem.dmem[ca]) hit = i;
        @(negedge sys_clk);
        range_addr = 16'(ra);
        count_operand = bcd(n);
        compare_addr = 16'(ca);
        range_in_data_area = dm;
        go(2'h0);
        chk(16'(match_flag), 16'(hit >= 0), "match");
        chk(u_mem.dmem[ca + 1], hit < 0 ? old : bcd(dm ? ra + hit : hit), "result");
        $display("lookup test done");
    endtask
    initial begin
        for (int i = 0; i < 1024; i++) begin
            u_mem.dmem[i] = 16'($random(seed));
            u_mem.xmem[i] = 16'($random(seed));
        end
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        rd_st(wsc_pkg::STATUS_OFFSET, 1'b0, 16'h0000);
        u_mem.dmem[0] = 16'hFFFF;
        u_mem.dmem[12] = 16'hFFFF;
        u_mem.dmem[19] = 16'hFFFF;
        lookup(10, 10, 0, 1'b1);
        slow = 1'b1;
        u_mem.dmem[200] = 16'h1234;
        u_mem.dmem[114] = 16'h1234;
        lookup(14, 101, 200, 1'b0);
        lookup(20, 10, 300, 1'b1);
        // block copy with power loss flagged, memory stalling
        @(negedge sys_clk);
        power_fail = 1'b1;
        count_operand = 16'h0003;
        source_operand = 16'h7000;
        dest_addr = 16'h01F4;
        go(2'h1);
        power_fail = 1'b0;
        for (int i = 0; i < 3; i++) chk(u_mem.dmem[500 + i], u_mem.xmem[(7000 + i) % 1024], "copy");
        chk(16'({fault_flag, got_done[0]}), 16'h0001, "copy end");
        // refused operands, one table row each
        foreach (bad[i]) begin
            @(negedge sys_clk);
            {op_code, count_operand, source_operand, control_operand} = bad[i];
            go(bad[i][49:48]);
            chk(16'({fault_flag, got_done[0]}), 16'h0003, "refused");
        end
        @(negedge sys_clk);
        indirect_bad = 1'b1;
        go(2'h2);
        indirect_bad = 1'b0;
        chk(16'(fault_flag), 16'h0001, "indirect");
        $display("fault test done");
        // every select code, status seen by program and by tool
        foreach (codes[i]) begin
            @(negedge sys_clk);
            control_operand = codes[i];
            go(2'h2);
            if (codes[i][7:4] == 4'hB) bank = int'(codes[i][1:0]);
            tgt = int'(codes[i] != 16'h0000);
            chk({fault_flag, 13'h0000, extra_bank}, 16'(bank), "bank");
            rd_st(wsc_pkg::STATUS_OFFSET, 1'b0, {tgt != 0 ? 8'h80 : 8'h00, 8'(bank)});
            rd_st(wsc_pkg::STATUS_OFFSET, 1'b1, 16'(bank));
        end
        rd_st(16'h1790, 1'b0, 16'h0000);
        @(negedge sys_clk);
        exec_cond = 1'b0;
        control_operand = 16'hE0B2;
        go(2'h2);
        exec_cond = 1'b1;
        chk({15'h0000, got_done[0]}, 16'h0000, "ignored");
        @(negedge sys_clk);
        scan_start = 1'b1;
        @(negedge sys_clk);
        scan_start = 1'b0;
        rd_st(wsc_pkg::STATUS_OFFSET, 1'b0, 16'h0001);
        @(negedge sys_clk);
        control_operand = 16'hE000;
        go(2'h2);
        interrupt_entry = 1'b1;
        @(negedge sys_clk);
        interrupt_entry = 1'b0;
        rd_st(wsc_pkg::STATUS_OFFSET, 1'b0, 16'h0001);
        $display("bank test done");
        tally_and_finish();
    end
endmodule
bind wsc_unit wsc_unit_chk #(.AW(AW)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .op_start(op_start),
    .op_code(op_code), .exec_cond(exec_cond), .control_operand(control_operand), .indirect_bad(indirect_bad),
    .scan_start(scan_start), .interrupt_entry(interrupt_entry), .mem_req(mem_req), .mem_ack(mem_ack),
    .mem_addr(mem_addr), .extra_bank(extra_bank), .indirect_to_extra(indirect_to_extra),
    .status_rd(status_rd), .status_rd_tool(status_rd_tool), .status_rd_addr(status_rd_addr),
    .status_rdata(status_rdata), .op_done(op_done), .op_busy(op_busy), .match_flag(match_flag),
    .fault_flag(fault_flag));
`default_nettype wire
